// File: sel_pkg.sv
/* Shared constants, types and helpers of the read result
   output selector: register map, condition bits, states.
   Assumes one 100 MHz ref_clk for the whole block. */
package sel_pkg;
  localparam int NTOOL = 8;            // Decode tools per job
  localparam int NOUT = 3;             // Output lines
  localparam int NCOND = 13;           // Selectable conditions
  localparam int CLK_PERIOD_NS = 10;   // ref_clk period
  localparam int US_NS = 1000;         // One microsecond
  localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
  localparam int PRE_W = $clog2(CYC_PER_US);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_US - 1);
  localparam int US_W = 24;            // Holds the longest time
  localparam int DEF_PULSE_US = 1000;  // Default on and off time
  localparam int MAX_PULSE_US = 10000000; // Longest on or off time
  // Condition bit positions
  localparam int C_DONE = 0;
  localparam int C_PASS = 1;
  localparam int C_FAIL = 2;
  localparam int C_APRES = 3;
  localparam int C_AREAD = 4;
  localparam int C_AMATCH = 5;
  localparam int C_GOOD = 6;
  localparam int C_NPRES = 7;
  localparam int C_NREAD = 8;
  localparam int C_NMATCH = 9;
  localparam int C_POOR = 10;
  localparam int C_OVR = 11;
  localparam int C_GERR = 12;
  // Register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SEL0 = 8'h04;
  localparam logic [7:0] A_ON0 = 8'h10;
  localparam logic [7:0] A_OFF0 = 8'h1c;
  localparam logic [7:0] A_STAT = 8'h28;
  localparam logic [7:0] A_STEP = 8'h04;
  // Control and status fields
  localparam int F_STROBE = 0;
  localparam int F_NC = 1;
  localparam int F_ST = 16;
  localparam int F_TBUSY = 18;
  typedef logic [US_W-1:0] us_t;
  typedef logic [NCOND-1:0] cond_t;
  localparam us_t US_ONE = 24'h000001;
  localparam logic [NOUT-1:0] NC_RST = 3'h0;
  localparam cond_t SEL_RST [NOUT] = '{13'h0002, 13'h0004, 13'h1800};
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT_TX = 2'b01,
    S_FIRE = 2'b10,
    S_HOLD = 2'b11
  } sel_state_t;
  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_ON = 2'b01,
    T_OFF = 2'b10
  } tmr_state_t;
  // Per-tool results of one read cycle
  typedef struct packed {
    logic [NTOOL-1:0] used;
    logic [NTOOL-1:0] found;
    logic [NTOOL-1:0] read;
    logic [NTOOL-1:0] match;
    logic [NTOOL-1:0] ver_en;
    logic [NTOOL-1:0] ver_pass;
  } tool_res_t;
  // Trigger path state
  typedef struct packed {
    logic trigger;
    logic acq_busy;
    logic no_free_buf;
  } ovr_in_t;
  // True when every used tool reports ok
  function automatic logic all_of(input logic [NTOOL-1:0] used,
                                  input logic [NTOOL-1:0] ok);
    return &(ok | ~used);
  endfunction
  function automatic logic [7:0] reg_at(input logic [7:0] base, input int idx);
    return base + A_STEP * 8'(idx);
  endfunction
  // Writes above the longest time saturate
  function automatic us_t clamp_us(input logic [31:0] v);
    return (v > MAX_PULSE_US) ? us_t'(MAX_PULSE_US) : v[US_W-1:0];
  endfunction
endpackage

// File: pulse_timer.sv
/* One output pulse: on phase then off phase, counted in
   microsecond ticks. Assumes us_tick aligned to start. */
`timescale 1ns/1ps
module pulse_timer (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic         start,
  input  wire logic         us_tick,
  input  wire sel_pkg::us_t on_us,
  input  wire sel_pkg::us_t off_us,
  output logic              active,
  output logic              busy
);
  import sel_pkg::*;

  tmr_state_t st_r;  // Phase
  us_t        cnt_r; // Microseconds left

  // Phase sequencer; a zero phase is skipped
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= T_IDLE;
      cnt_r <= '0;
    end else begin
      unique case (st_r)
        T_IDLE: if (start && on_us != '0) begin
          st_r <= T_ON;
          cnt_r <= on_us;
        end else if (start && off_us != '0) begin
          st_r <= T_OFF;
          cnt_r <= off_us;
        end
        T_ON: if (us_tick && cnt_r == US_ONE) begin
          st_r <= (off_us != '0) ? T_OFF : T_IDLE;
          cnt_r <= off_us;
        end else if (us_tick) begin
          cnt_r <= cnt_r - US_ONE;
        end
        T_OFF: if (us_tick && cnt_r == US_ONE) begin
          st_r <= T_IDLE;
        end else if (us_tick) begin
          cnt_r <= cnt_r - US_ONE;
        end
        default: st_r <= T_IDLE; // Code 11 unused
      endcase
    end
  end

  assign active = (st_r == T_ON);
  assign busy = (st_r != T_IDLE);
endmodule // pulse_timer

// File: ovr_detect.sv
/* Trigger and processing overrun flags, sticky until the
   read cycle is sampled. Assumes same-clock inputs. */
`timescale 1ns/1ps
module ovr_detect (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire sel_pkg::ovr_in_t ovr,
  input  wire logic             clr,
  output logic                  trig_ovr,
  output logic                  proc_ovr
);
  import sel_pkg::*;

  logic trig_r;   // Trigger overrun seen
  logic proc_r;   // Processing overrun seen
  logic trig_evt; // New trigger while acquiring
  logic proc_evt; // New trigger with no buffer

  assign trig_evt = ovr.trigger & ovr.acq_busy;
  assign proc_evt = ovr.trigger & ovr.no_free_buf;

  // Set wins over clear so no event is lost
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_r <= 1'b0;
      proc_r <= 1'b0;
    end else begin
      trig_r <= trig_evt | (trig_r & ~clr);
      proc_r <= proc_evt | (proc_r & ~clr);
    end
  end

  // Current event counts at once
  assign trig_ovr = trig_r | trig_evt;
  assign proc_ovr = proc_r | proc_evt;
endmodule // ovr_detect

// File: result_out_sel.sv
/* Read result output selector: samples the results of a
   read cycle, matches them against each line's selection
   and drives three pulsed output lines.
   Assumes result, trigger and fault inputs on ref_clk and
   a plain register port with one-cycle strobes. */
// Added by the designer: the address map and the strobed register port.
// How it works
// - Complete fires only after data sent
// - Pass needs all found, read, matched
// - Fail when anything absent or unmatched
// - All present: every tool found code
// - All read: every tool right content
// - All match: every tool fully matched
// - Match in use keeps decoder searching
// - Good quality: enabled verifications all pass
// - Unfound code skips verification
// - Not all present: a tool missed
// - Not all read: a tool lacks content
// - Not all match: a tool failed match
// - Poor quality: a verification failed
// - Overrun is trigger or processing overrun
// - Trigger during acquisition is trigger overrun
// - Trigger without free buffer: processing overrun
// - General error on any subsystem fault
// - Only line three may be strobe
// - Line fires on OR of selections
// - Programmable on time then off time
`timescale 1ns/1ps
module result_out_sel #(
  parameter int DEF_ON_US  = sel_pkg::DEF_PULSE_US, // On time after reset
  parameter int DEF_OFF_US = sel_pkg::DEF_PULSE_US  // Off time after reset
) (
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  input  wire logic              cycle_end,
  input  wire logic              data_sent,
  input  wire sel_pkg::tool_res_t tools,
  input  wire sel_pkg::ovr_in_t  ovr,
  input  wire logic [3:0]        faults,
  input  wire logic              illum_strobe,
  output logic [2:0]             out_line,
  output logic                   cycle_busy,
  output logic                   keep_search
);
  import sel_pkg::*;

  sel_state_t      st_r;          // Cycle sequencer
  cond_t           snap_r;        // Results of the cycle
  cond_t           sel_r [NOUT];  // Per-line selection
  us_t             on_r [NOUT];   // On time, us
  us_t             off_r [NOUT];  // Off time, us
  logic            strobe_en_r;   // Line three as strobe
  logic [NOUT-1:0] nc_r;          // Normally closed lines
  logic            gerr_r;        // Fault seen this cycle
  logic [PRE_W-1:0] pre_r;        // Microsecond prescaler
  logic [2:0]      line_r;        // Output line levels
  logic            search_r;      // Matching in use
  logic [31:0]     rdata_r;       // Read answer
  logic [31:0]     rd_nxt;        // Read mux
  logic [NOUT-1:0] act;           // Timer on phases
  logic [NOUT-1:0] tbusy;         // Timers running
  logic [NOUT-1:0] hit;           // Line has a true selection
  logic [NOUT-1:0] start;         // Timer start pulses
  logic [2:0]      line_nxt;      // Next line levels
  logic            trig_ovr;      // Trigger overrun
  logic            proc_ovr;      // Processing overrun
  logic            cap;           // Sample the cycle
  logic            go_fire;       // Data out, evaluate
  logic            us_tick;       // One per microsecond
  logic [NTOOL-1:0] vgate;        // Tools that verify
  cond_t           cond_now;      // Live conditions

  // Cycle end only counts when idle
  assign cap = (st_r == S_IDLE) & cycle_end;
  assign go_fire = data_sent & (cap | (st_r == S_WAIT_TX));

  // Verification only where the code was found
  assign vgate = tools.used & tools.found & tools.ver_en;

  // Live view of every selectable condition
  always_comb begin
    cond_now = '0;
    cond_now[C_DONE] = data_sent;
    cond_now[C_APRES] = all_of(tools.used, tools.found);
    cond_now[C_AREAD] = all_of(tools.used, tools.found & tools.read);
    cond_now[C_AMATCH] = all_of(tools.used,
                                tools.found & tools.read & tools.match);
    cond_now[C_GOOD] = all_of(vgate, tools.ver_pass);
    cond_now[C_PASS] = cond_now[C_APRES] & cond_now[C_AREAD]
                       & cond_now[C_AMATCH];
    cond_now[C_FAIL] = ~cond_now[C_PASS];
    cond_now[C_NPRES] = ~cond_now[C_APRES];
    cond_now[C_NREAD] = ~cond_now[C_AREAD];
    cond_now[C_NMATCH] = ~cond_now[C_AMATCH];
    cond_now[C_POOR] = |(vgate & ~tools.ver_pass);
    cond_now[C_OVR] = trig_ovr | proc_ovr;
    cond_now[C_GERR] = gerr_r | (|faults);
  end

  // Overrun flags cleared when the cycle is sampled
  ovr_detect u_ovr (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .ovr      (ovr),
    .clr      (cap),
    .trig_ovr (trig_ovr),
    .proc_ovr (proc_ovr)
  );

  // Sticky fault flag, set wins over clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gerr_r <= 1'b0;
    end else begin
      gerr_r <= (|faults) | (gerr_r & ~cap);
    end
  end

  // Read cycle sequencer; pulses lengthen the cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= S_IDLE;
    end else begin
      unique case (st_r)
        S_IDLE: if (cap) begin
          st_r <= data_sent ? S_FIRE : S_WAIT_TX;
        end
        S_WAIT_TX: if (data_sent) begin
          st_r <= S_FIRE;
        end
        S_FIRE: st_r <= S_HOLD;
        S_HOLD: if (tbusy == '0) begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end

  // Results frozen once per cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      snap_r <= '0;
    end else if (cap) begin
      snap_r <= cond_now;
    end else if (go_fire) begin
      snap_r[C_DONE] <= 1'b1;
    end
  end

  // Prescaler restarts at fire so on time is exact
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_r <= '0;
    end else if (st_r == S_FIRE || pre_r == PRE_LAST) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end
  assign us_tick = (pre_r == PRE_LAST);

  // One timer per line, started on any true selection
  for (genvar g = 0; g < NOUT; g++) begin : g_line
    assign hit[g] = |(sel_r[g] & snap_r);
    assign start[g] = (st_r == S_FIRE) & hit[g];
    pulse_timer u_tmr (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .start   (start[g]),
      .us_tick (us_tick),
      .on_us   (on_r[g]),
      .off_us  (off_r[g]),
      .active  (act[g]),
      .busy    (tbusy[g])
    );
  end

  // Strobe may replace the pulse on line three only
  always_comb begin
    line_nxt = act;
    if (strobe_en_r) begin
      line_nxt[2] = illum_strobe;
    end
  end

  // Lines registered, with normal state applied
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      line_r <= NC_RST;
    end else begin
      line_r <= line_nxt ^ nc_r;
    end
  end
  assign out_line = line_r;

  // Decoder must hunt for a full match when any line uses it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      search_r <= 1'b0;
    end else begin
      search_r <= 1'b0;
      for (int i = 0; i < NOUT; i++) begin
        if (sel_r[i][C_PASS] | sel_r[i][C_FAIL] | sel_r[i][C_AMATCH]
            | sel_r[i][C_NMATCH]) begin
          search_r <= 1'b1;
        end
      end
    end
  end
  assign keep_search = search_r;
  assign cycle_busy = (st_r != S_IDLE);

  // Register writes; on time changes take effect next pulse, off time changes at the next off phase
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_en_r <= 1'b0;
      nc_r <= NC_RST;
      for (int i = 0; i < NOUT; i++) begin
        sel_r[i] <= SEL_RST[i];
        on_r[i] <= us_t'(DEF_ON_US);
        off_r[i] <= us_t'(DEF_OFF_US);
      end
    end else if (reg_wr) begin
      if (reg_addr == A_CTRL) begin
        strobe_en_r <= reg_wdata[F_STROBE];
        nc_r <= reg_wdata[F_NC +: NOUT];
      end
      for (int i = 0; i < NOUT; i++) begin
        if (reg_addr == reg_at(A_SEL0, i)) begin
          sel_r[i] <= reg_wdata[NCOND-1:0];
        end
        if (reg_addr == reg_at(A_ON0, i)) begin
          on_r[i] <= clamp_us(reg_wdata);
        end
        if (reg_addr == reg_at(A_OFF0, i)) begin
          off_r[i] <= clamp_us(reg_wdata);
        end
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_nxt = '0;
    if (reg_addr == A_CTRL) begin
      rd_nxt[F_STROBE] = strobe_en_r;
      rd_nxt[F_NC +: NOUT] = nc_r;
    end else if (reg_addr == A_STAT) begin
      rd_nxt[NCOND-1:0] = snap_r;
      rd_nxt[F_ST +: 2] = st_r;
      rd_nxt[F_TBUSY +: NOUT] = tbusy;
    end
    for (int i = 0; i < NOUT; i++) begin
      if (reg_addr == reg_at(A_SEL0, i)) begin
        rd_nxt[NCOND-1:0] = sel_r[i];
      end
      if (reg_addr == reg_at(A_ON0, i)) begin
        rd_nxt[US_W-1:0] = on_r[i];
      end
      if (reg_addr == reg_at(A_OFF0, i)) begin
        rd_nxt[US_W-1:0] = off_r[i];
      end
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd ? rd_nxt : '0;
    end
  end
  assign reg_rdata = rdata_r;

  // Checks on the sequencer and the lines
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_tx_wait;
    st_r == S_WAIT_TX && data_sent;
  endsequence
  sequence s_fire_hold;
    st_r == S_FIRE ##1 st_r == S_HOLD;
  endsequence

  a_fire_after_tx: assert property (s_tx_wait |=> s_fire_hold)
    else $error("no fire after data sent");
  a_fire_needs_tx: assert property (st_r == S_FIRE |-> $past(data_sent))
    else $error("fire without data sent");
  a_pass_cause: assert property (cap |=> snap_r[C_PASS] ==
      $past(all_of(tools.used, tools.found & tools.read & tools.match)))
    else $error("pass does not follow results");
  a_fail_inverse: assert property (st_r == S_FIRE |->
      snap_r[C_FAIL] != snap_r[C_PASS])
    else $error("fail equals pass");
  a_present_pair: assert property (cap |=>
      snap_r[C_NPRES] != snap_r[C_APRES]
      && snap_r[C_APRES] == $past(all_of(tools.used, tools.found)))
    else $error("present flags wrong");
  a_verify_skip: assert property (cap && !(|(tools.used & tools.found
      & tools.ver_en & ~tools.ver_pass)) |=> !snap_r[C_POOR])
    else $error("poor quality without found failure");
  a_trig_ovr: assert property (ovr.trigger && ovr.acq_busy
      |=> trig_ovr && snap_r[C_OVR] == $past(cap | snap_r[C_OVR]) || !$past(cap))
    else $error("trigger overrun lost");
  a_proc_ovr: assert property (ovr.trigger && ovr.no_free_buf |=> proc_ovr)
    else $error("processing overrun lost");
  a_gerr_held: assert property (|faults |=> gerr_r)
    else $error("fault not held");
  a_or_start: assert property (st_r == S_FIRE && hit[0] && on_r[0] != '0
      |=> act[0])
    else $error("selected line did not fire");
  a_on_hold: assert property ($rose(act[0]) |-> act[0] [*8])
    else $error("on phase too short");
  a_strobe_line: assert property (strobe_en_r |=>
      out_line[2] == $past(illum_strobe ^ nc_r[2]))
    else $error("strobe not on line three");
  a_low_lines: assert property (1'b1 |=>
      out_line[1:0] == $past(act[1:0] ^ nc_r[1:0]))
    else $error("lines one and two not pulse driven");
  a_snap_stable: assert property (st_r == S_HOLD |=> $stable(snap_r))
    else $error("results changed after evaluation");

  // Sampling with no fresh trigger in its own cycle or the next
  sequence s_cap_quiet;
    (cap && !ovr.trigger) ##1 !ovr.trigger;
  endsequence

  a_done_late: assert property (st_r == S_WAIT_TX |-> !snap_r[C_DONE])
    else $error("complete set before data sent");
  a_search_used: assert property (sel_r[0][C_AMATCH] |=> keep_search)
    else $error("match selected but search off");
  a_ovr_cleared: assert property (s_cap_quiet |-> !trig_ovr && !proc_ovr)
    else $error("overrun kept past sampling");
  a_rest_idle: assert property (st_r == S_IDLE && !strobe_en_r
      |=> out_line == $past(nc_r))
    else $error("line active outside a cycle");
  a_zero_on: assert property (start[1] && on_r[1] == '0 |=> !act[1])
    else $error("zero on time gave a pulse");
  a_off_hold: assert property ($fell(act[0]) && $past(off_r[0] != '0)
      |-> tbusy[0] [*8])
    else $error("off phase too short");
  a_on_clamp: assert property (reg_wr && reg_addr == reg_at(A_ON0, 2)
      && reg_wdata > MAX_PULSE_US |=> on_r[2] == us_t'(MAX_PULSE_US))
    else $error("on time not saturated");
endmodule // result_out_sel

// File: host_model.sv
/* Host that samples the three output lines: counts the
   active pulses of each line and the width of the last.
   Assumes nc mirrors the normally-closed control bits. */
`timescale 1ns/1ps
module host_model (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic [2:0]  out_line,
  input  wire logic [2:0]  nc,
  output logic [2:0][7:0]  pulses,
  output logic [2:0][15:0] width
);
  logic [2:0][15:0] run_r; // Edges seen active so far

  // Log each active run when the line returns to rest
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_r  <= '0;
      pulses <= '0;
      width  <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (out_line[i] ^ nc[i]) begin
          run_r[i] <= run_r[i] + 16'h0001;
        end else if (run_r[i] != 16'h0000) begin
          // Run ended: width is in whole clock edges
          run_r[i]  <= 16'h0000;
          width[i]  <= run_r[i];
          pulses[i] <= pulses[i] + 8'h01;
        end
      end
    end
  end
endmodule // host_model

// File: tb_top.sv
/* Self-checking bench of result_out_sel: register tasks,
   a read cycle driver and pulse checks at the host.
   Assumes host_model watches out_line beside the design. */
`timescale 1ns/1ps
module tb_top;
  import sel_pkg::*;
  localparam logic [47:0] PASS_V = 48'hff_ff_ff_ff_ff_7f; // Pass, one poor
  localparam logic [47:0] MIX_V  = 48'h07_03_03_01_06_02; // Tool 2 missing
  localparam logic [47:0] FAIL_V = 48'hff_ff_ff_fe_00_00; // One mismatch
  logic             ref_clk = 1'b0;
  logic             arst_n = 1'b0;
  logic [7:0]       reg_addr = 8'h00;
  logic [31:0]      reg_wdata = 32'h0;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic [31:0]      reg_rdata;
  logic             cycle_end = 1'b0;
  logic             data_sent = 1'b0;
  tool_res_t        tools = '0;
  ovr_in_t          ovr = '0;
  logic [3:0]       faults = 4'h0;
  logic             illum_strobe = 1'b0;
  logic [2:0]       out_line;
  logic             cycle_busy;
  logic             keep_search;
  logic [2:0]       nc_v = 3'h0;      // Host copy of rest levels
  logic [2:0][7:0]  pulses;
  logic [2:0][15:0] width;
  logic [2:0][7:0]  prev = '0;        // Pulse counts already judged
  int               num_errors = 0;
  int               checks_done = 0;
  int               cyc = 0;

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  result_out_sel #(.DEF_ON_US(1), .DEF_OFF_US(1)) u_result_out_sel (
    .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cycle_end(cycle_end), .data_sent(data_sent),
    .tools(tools), .ovr(ovr), .faults(faults), .illum_strobe(illum_strobe),
    .out_line(out_line), .cycle_busy(cycle_busy), .keep_search(keep_search));

  host_model u_host_model (.ref_clk(ref_clk), .arst_n(arst_n),
    .out_line(out_line), .nc(nc_v), .pulses(pulses), .width(width));

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Guard against a hang; the run needs about 6500 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      $display("CHECK FAILED t=%0t timeout", $time);
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string msg);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp, msg);
  endtask

  task automatic run_cycle(input logic [47:0] t, input logic sent);
    @(posedge ref_clk);
    tools <= t;
    cycle_end <= 1'b1;
    data_sent <= sent;
    @(posedge ref_clk);
    cycle_end <= 1'b0;
    data_sent <= 1'b0;
  endtask

  // Bounded wait for the pulses of a cycle to finish
  task automatic idle_wait;
    int n;
    n = 0;
    #1;
    while (cycle_busy !== 1'b0 && n < 3000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(32'(n < 3000), 32'h1, "busy stuck");
  endtask

  task automatic pulses_chk(input logic [2:0] e);
    for (int i = 0; i < 3; i++) begin
      check(32'(pulses[i] - prev[i]), 32'(e[i]), "pulse count");
      prev[i] = pulses[i];
    end
  endtask

  initial begin
    logic [12:0] c;
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    rc(A_CTRL, 32'h0, "ctrl reset");
    for (int i = 0; i < 3; i++) begin
      rc(A_SEL0 + 8'(4 * i), 32'(SEL_RST[i]), "sel reset");
    end
    rc(A_ON0, 32'h1, "on reset");
    wr(8'h2c, 32'hffffffff);
    rc(8'h2c, 32'h0, "unmapped");
    check(32'(keep_search), 32'h1, "search default");
    // Strobe: ignored until enabled, then on line three only
    @(posedge ref_clk);
    illum_strobe <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check(32'(out_line), 32'h0, "strobe off");
    wr(A_CTRL, 32'h1);
    repeat (2) @(posedge ref_clk);
    #1;
    check(32'(out_line), 32'h4, "strobe on");
    @(posedge ref_clk);
    illum_strobe <= 1'b0;
    repeat (2) @(posedge ref_clk);
    wr(A_CTRL, 32'h0);
    pulses_chk(3'b100);
    // Default selections with default vectors
    run_cycle(PASS_V, 1'b1);
    idle_wait();
    pulses_chk(3'b001);
    run_cycle(FAIL_V, 1'b1);
    idle_wait();
    pulses_chk(3'b010);
    // Normally-closed lines pulse towards 0
    wr(A_CTRL, 32'h0000000e);
    nc_v <= 3'b111;
    repeat (4) @(posedge ref_clk);
    prev = pulses;
    check(32'(out_line), 32'h7, "rest level");
    run_cycle(PASS_V, 1'b1);
    idle_wait();
    pulses_chk(3'b001);
    wr(A_CTRL, 32'h0);
    nc_v <= 3'b000;
    repeat (4) @(posedge ref_clk);
    prev = pulses;
    // Complete waits for the data to be sent
    wr(A_SEL0, 32'h1);
    run_cycle(PASS_V, 1'b0);
    repeat (20) @(posedge ref_clk);
    #1;
    check(32'(out_line), 32'h0, "early complete");
    @(posedge ref_clk);
    data_sent <= 1'b1;
    @(posedge ref_clk);
    data_sent <= 1'b0;
    idle_wait();
    pulses_chk(3'b001);
    // Each condition alone on line one, two result vectors
    for (int v = 0; v < 2; v++) begin
      c = (v == 0) ? 13'h043b : 13'h03c5;
      for (int k = 0; k < 13; k++) begin
        wr(A_SEL0, 32'h1 << k);
        run_cycle((v == 0) ? PASS_V : MIX_V, 1'b1);
        idle_wait();
        rc(A_STAT, 32'(c), "sampled conditions");
        pulses_chk({1'b0, c[C_FAIL], c[k]});
      end
    end
    wr(A_SEL0, 32'h2);
    // Overruns and faults are sticky until sampled
    @(posedge ref_clk);
    ovr <= 3'b110;
    @(posedge ref_clk);
    ovr <= 3'b010;
    @(posedge ref_clk);
    ovr <= 3'b000;
    run_cycle(PASS_V, 1'b1);
    idle_wait();
    pulses_chk(3'b101);
    @(posedge ref_clk);
    ovr <= 3'b100;
    @(posedge ref_clk);
    ovr <= 3'b000;
    run_cycle(PASS_V, 1'b1);
    idle_wait();
    pulses_chk(3'b001);
    @(posedge ref_clk);
    ovr <= 3'b101;
    @(posedge ref_clk);
    ovr <= 3'b000;
    run_cycle(PASS_V, 1'b1);
    idle_wait();
    pulses_chk(3'b101);
    @(posedge ref_clk);
    faults <= 4'h4;
    @(posedge ref_clk);
    faults <= 4'h0;
    run_cycle(PASS_V, 1'b1);
    idle_wait();
    pulses_chk(3'b101);
    // Keep searching only while a match-based condition is used
    wr(A_SEL0, 32'h1);
    wr(A_SEL0 + 8'h04, 32'h1);
    wr(A_SEL0 + 8'h08, 32'h0800);
    repeat (3) @(posedge ref_clk);
    check(32'(keep_search), 32'h0, "search off");
    wr(A_SEL0 + 8'h08, 32'h0200);
    repeat (3) @(posedge ref_clk);
    check(32'(keep_search), 32'h1, "search on");
    // On time in microseconds, zero gives no pulse
    wr(A_SEL0, 32'h4);
    wr(A_SEL0 + 8'h04, 32'h4);
    wr(A_SEL0 + 8'h08, 32'h0);
    wr(A_ON0, 32'h2);
    wr(A_ON0 + 8'h04, 32'h0);
    wr(A_OFF0, 32'h3);
    rc(A_OFF0, 32'h3, "off readback");
    run_cycle(FAIL_V, 1'b1);
    // Off phase of line one still running, cycle held in hold
    repeat (350) @(posedge ref_clk);
    rc(A_STAT, 32'h0007025d, "off phase busy");
    // A cycle end during hold is refused
    run_cycle(PASS_V, 1'b1);
    idle_wait();
    rc(A_STAT, 32'h0000025d, "busy cycle refused");
    pulses_chk(3'b001);
    check(32'(width[0]), 32'd200, "on width");
    wr(A_ON0 + 8'h08, 32'hffffffff);
    rc(A_ON0 + 8'h08, 32'd10000000, "on ceiling");
    tally_and_finish();
  end
endmodule // tb_top
